// *** logic/drive_word_pkg.sv ***
// Package: drive word layout, decode tables and shared carrier types
package drive_word_pkg;

    // Drive word width and field positions
    localparam int WORD_W          = 16;
    localparam int PEAK_LSB        = 0;
    localparam int B_DECAY_LSB     = 2;
    localparam int B_STEP_LSB      = 4;
    localparam int B_POL_BIT       = 8;
    localparam int A_DECAY_LSB     = 9;
    localparam int A_STEP_LSB      = 11;
    localparam int A_POL_BIT       = 15;
    localparam int WINDINGS        = 2;

    // Initial setup latch fields used here
    localparam int MOTOR_SEL_LSB   = 0;
    localparam int BLANK_SEL_LSB   = 3;

    // Reset value and stepping motor select codes
    localparam logic [15:0] WORD_RESET  = 16'h0000;
    localparam logic [2:0]  SEL_STEPPER2 = 3'h0;
    localparam logic [2:0]  SEL_STEP_DCL = 3'h1;
    localparam logic [2:0]  SEL_STEP_DCS = 3'h2;

    // Decay and step codes
    localparam logic [1:0]  DECAY_FAST  = 2'h3;
    localparam logic [3:0]  STEP_OFF    = 4'h0;

    // Peak current range in percent, indexed by bits 1:0
    localparam logic [6:0] PEAK_PCT [4] = '{7'h32, 7'h46, 7'h55, 7'h64};

    // Step current in percent of peak, indexed by 4-bit step code
    localparam logic [6:0] STEP_PCT [16] = '{
        7'h00, 7'h0A, 7'h14, 7'h1D, 7'h26, 7'h2F, 7'h38, 7'h3F,
        7'h47, 7'h4D, 7'h53, 7'h58, 7'h5C, 7'h60, 7'h62, 7'h64};

    // Blanking length in oscillator periods, indexed by setup bits 4:3
    localparam logic [2:0] BLANK_PERIODS [4] = '{3'h5, 3'h2, 3'h3, 3'h4};

    // Decoded drive of one winding
    typedef struct packed {
        logic [1:0] decay;
        logic [6:0] stepPct;
        logic       off;
        logic       posHigh;
        logic       negHigh;
    } winding_drive_t;

    // Pins sampled from outside the clock domain
    typedef struct packed {
        logic strobe;
        logic standby;
        logic data;
        logic polarity;
    } pin_sample_t;

endpackage : drive_word_pkg

// *** logic/stepper_drive_word_latch.sv ***
// Serial drive word latch with setup latches, decode and DC blanking
module stepper_drive_word_latch (
    // System clock and reset
    input  wire logic                           clk,
    input  wire logic                           reset_n,
    // Serial link from host
    input  wire logic                           shift_clock_pair_one,
    input  wire logic                           serial_in_pair_one,
    input  wire logic                           load_pulse_pair_one,
    input  wire logic                           standbySelect,
    // Chopper side inputs
    input  wire logic                           bridgePolarity,
    input  wire logic                           chargeStart,
    input  wire logic                           chopOscTick,
    // Latch contents
    output logic [drive_word_pkg::WORD_W-1:0]   motor_drive_word,
    output logic [drive_word_pkg::WORD_W-1:0]   initialSetupWord,
    output logic [drive_word_pkg::WORD_W-1:0]   extendedSetupWord,
    // Decoded drive
    output logic [6:0]                          peakScalePct,
    output drive_word_pkg::winding_drive_t      windingA,
    output drive_word_pkg::winding_drive_t      windingB,
    output logic                                motorOperation,
    output logic                                dcMode,
    output logic                                noise_blank_interval
);

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: shift register

    logic [drive_word_pkg::WORD_W-1:0] shiftWord;

    // MSB first shift on each rising shift clock
    always_ff @(posedge shift_clock_pair_one) begin
        shiftWord <= {shiftWord[drive_word_pkg::WORD_W-2:0], serial_in_pair_one};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    drive_word_pkg::pin_sample_t pinsIn;
    drive_word_pkg::pin_sample_t syncA;
    drive_word_pkg::pin_sample_t syncB;
    drive_word_pkg::pin_sample_t syncC;
    drive_word_pkg::pin_sample_t pinState;

    assign pinsIn = '{strobe: load_pulse_pair_one, standby: standbySelect,
                      data: serial_in_pair_one, polarity: bridgePolarity};

    // Three stage chain; only syncB and syncC are looked at
    always_ff @(posedge clk) begin
        syncA <= pinsIn;
        syncB <= syncA;
        syncC <= syncB;
    end

    // Accepted pin levels: a bit changes once syncB and syncC agree
    genvar p;
    generate
        for (p = 0; p < $bits(drive_word_pkg::pin_sample_t); p++) begin : g_pin
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    pinState[p] <= 1'b0;
                end else if (syncB[p] == syncC[p]) begin
                    pinState[p] <= syncC[p];
                end
            end
        end
    endgenerate

    // Qualified events in the clock domain
    logic loadEdge;
    logic standbyToggle;
    logic polarityToggle;
    logic standbyAtLoad;
    logic dataAtLoad;

    assign loadEdge       = (syncB.strobe == syncC.strobe) && syncC.strobe && !pinState.strobe;
    assign standbyToggle  = (syncB.standby == syncC.standby)
                            && (syncC.standby != pinState.standby);
    assign polarityToggle = (syncB.polarity == syncC.polarity)
                            && (syncC.polarity != pinState.polarity);
    assign standbyAtLoad  = (syncB.standby == syncC.standby) ? syncC.standby : pinState.standby;
    assign dataAtLoad     = (syncB.data == syncC.data) ? syncC.data : pinState.data;

    ////////////////////////////////////////////////////////////////////////////
    // Latches

    // Motor drive latch: cleared by standby edges, loaded with standby high
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            motor_drive_word <= drive_word_pkg::WORD_RESET;
        end else if (standbyToggle) begin
            motor_drive_word <= drive_word_pkg::WORD_RESET;
        end else if (loadEdge && standbyAtLoad) begin
            motor_drive_word <= shiftWord;
        end
    end

    // Initial setup latch: standby low, data low at strobe
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            initialSetupWord <= drive_word_pkg::WORD_RESET;
        end else if (loadEdge && !standbyAtLoad && !dataAtLoad) begin
            initialSetupWord <= shiftWord;
        end
    end

    // Extended setup latch: standby low, data high at strobe
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            extendedSetupWord <= drive_word_pkg::WORD_RESET;
        end else if (loadEdge && !standbyAtLoad && dataAtLoad) begin
            extendedSetupWord <= shiftWord;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode and decode

    logic [2:0] motorSel;
    logic       next_dcMode;

    assign motorSel    = initialSetupWord[drive_word_pkg::MOTOR_SEL_LSB +: 3];
    assign next_dcMode = !(motorSel == drive_word_pkg::SEL_STEPPER2
                           || motorSel == drive_word_pkg::SEL_STEP_DCL
                           || motorSel == drive_word_pkg::SEL_STEP_DCS);

    // Operating mode flags
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            motorOperation <= 1'b0;
            dcMode         <= 1'b0;
        end else begin
            motorOperation <= pinState.standby;
            dcMode         <= next_dcMode;
        end
    end

    logic [1:0] peakCode;

    // Peak range field of the motor word
    assign peakCode = motor_drive_word[drive_word_pkg::PEAK_LSB +: 2];

    // Peak range, same table for either pair
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            peakScalePct <= 7'h00;
        end else begin
            peakScalePct <= drive_word_pkg::PEAK_PCT[peakCode];
        end
    end

    // Per winding decode: index 0 is A, 1 is B
    drive_word_pkg::winding_drive_t drive [drive_word_pkg::WINDINGS];
    localparam int DECAY_LSB [2] = '{drive_word_pkg::A_DECAY_LSB, drive_word_pkg::B_DECAY_LSB};
    localparam int STEP_LSB  [2] = '{drive_word_pkg::A_STEP_LSB, drive_word_pkg::B_STEP_LSB};
    localparam int POL_BIT   [2] = '{drive_word_pkg::A_POL_BIT, drive_word_pkg::B_POL_BIT};

    genvar w;
    generate
        for (w = 0; w < drive_word_pkg::WINDINGS; w++) begin : g_wind
            logic [3:0] step;
            logic [1:0] decayCode;
            logic       pol;
            assign step      = motor_drive_word[STEP_LSB[w] +: 4];
            assign decayCode = motor_drive_word[DECAY_LSB[w] +: 2];
            assign pol       = motor_drive_word[POL_BIT[w]];
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    // Zero word decoded, so the winding reads as off
                    drive[w] <= '{decay: 2'h0, stepPct: 7'h00, off: 1'b1,
                                  posHigh: 1'b0, negHigh: 1'b0};
                end else begin
                    drive[w].decay   <= next_dcMode ? drive_word_pkg::DECAY_FAST
                                                    : decayCode;
                    drive[w].stepPct <= drive_word_pkg::STEP_PCT[step];
                    drive[w].off     <= (step == drive_word_pkg::STEP_OFF);
                    drive[w].posHigh <= (step != drive_word_pkg::STEP_OFF) && pol;
                    drive[w].negHigh <= (step != drive_word_pkg::STEP_OFF) && !pol;
                end
            end
        end
    endgenerate

    assign windingA = drive[0];
    assign windingB = drive[1];

    ////////////////////////////////////////////////////////////////////////////
    // Digital noise blanking

    logic [2:0] blankCount;
    logic [2:0] blankLen;
    logic [1:0] blankSel;

    // Blanking length chosen by the initial setup word
    assign blankSel = initialSetupWord[drive_word_pkg::BLANK_SEL_LSB +: 2];
    assign blankLen = drive_word_pkg::BLANK_PERIODS[blankSel];

    // Started by polarity toggle or charge start, counted in oscillator ticks
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            blankCount           <= 3'h0;
            noise_blank_interval <= 1'b0;
        end else if (!next_dcMode) begin
            blankCount           <= 3'h0;
            noise_blank_interval <= 1'b0;
        end else if (polarityToggle || chargeStart) begin
            blankCount           <= blankLen;
            noise_blank_interval <= 1'b1;
        end else if (chopOscTick && blankCount != 3'h0) begin
            blankCount           <= blankCount - 3'h1;
            noise_blank_interval <= (blankCount != 3'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_standby_clear;
        @(posedge clk) disable iff (!reset_n)
        standbyToggle |=> motor_drive_word == drive_word_pkg::WORD_RESET;
    endproperty
    a_standby_clear: assert property (p_standby_clear)
        else $error("standby edge did not clear motor word");

    property p_motor_load;
        @(posedge clk) disable iff (!reset_n)
        loadEdge && standbyAtLoad && !standbyToggle |=> motor_drive_word == $past(shiftWord);
    endproperty
    a_motor_load: assert property (p_motor_load)
        else $error("motor word not loaded");

    property p_init_load;
        @(posedge clk) disable iff (!reset_n)
        loadEdge && !standbyAtLoad && !dataAtLoad
        |=> initialSetupWord == $past(shiftWord) && $stable(extendedSetupWord);
    endproperty
    a_init_load: assert property (p_init_load)
        else $error("initial setup load wrong");

    property p_ext_load;
        @(posedge clk) disable iff (!reset_n)
        loadEdge && !standbyAtLoad && dataAtLoad
        |=> extendedSetupWord == $past(shiftWord) && $stable(initialSetupWord)
            && $stable(motor_drive_word);
    endproperty
    a_ext_load: assert property (p_ext_load)
        else $error("extended setup load wrong");

    property p_no_load_keep;
        @(posedge clk) disable iff (!reset_n)
        !loadEdge && !standbyToggle |=> $stable(motor_drive_word) && $stable(initialSetupWord);
    endproperty
    a_no_load_keep: assert property (p_no_load_keep)
        else $error("latch changed without strobe");

    property p_peak;
        @(posedge clk) disable iff (!reset_n)
        motor_drive_word[1:0] == 2'h2 |=> peakScalePct == 7'h55;
    endproperty
    a_peak: assert property (p_peak)
        else $error("peak decode wrong");

    property p_off_step;
        @(posedge clk) disable iff (!reset_n)
        motor_drive_word[7:4] == 4'h0 |=> windingB.off && !windingB.posHigh && !windingB.negHigh;
    endproperty
    a_off_step: assert property (p_off_step)
        else $error("winding B not off");

    property p_step_pct;
        @(posedge clk) disable iff (!reset_n)
        motor_drive_word[14:11] == 4'h8 |=> windingA.stepPct == 7'h47;
    endproperty
    a_step_pct: assert property (p_step_pct)
        else $error("winding A step percent wrong");

    property p_polarity;
        @(posedge clk) disable iff (!reset_n)
        motor_drive_word[15] && motor_drive_word[14:11] != 4'h0 |=> windingA.posHigh;
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("winding A polarity wrong");

    property p_dc_fast;
        @(posedge clk) disable iff (!reset_n)
        next_dcMode |=> windingA.decay == 2'h3 && windingB.decay == 2'h3;
    endproperty
    a_dc_fast: assert property (p_dc_fast)
        else $error("DC mode not fast decay");

    property p_blank_step;
        @(posedge clk) disable iff (!reset_n)
        !next_dcMode |=> !noise_blank_interval;
    endproperty
    a_blank_step: assert property (p_blank_step)
        else $error("blanking in stepping mode");

    property p_blank_start;
        @(posedge clk) disable iff (!reset_n)
        next_dcMode && chargeStart |=> noise_blank_interval;
    endproperty
    a_blank_start: assert property (p_blank_start)
        else $error("blanking not started");

    property p_blank_pol;
        @(posedge clk) disable iff (!reset_n)
        next_dcMode && polarityToggle |=> noise_blank_interval;
    endproperty
    a_blank_pol: assert property (p_blank_pol)
        else $error("blanking not started by polarity change");

    property p_decay_pass;
        @(posedge clk) disable iff (!reset_n)
        !next_dcMode |=> windingB.decay == $past(motor_drive_word[3:2])
                         && windingA.decay == $past(motor_drive_word[10:9]);
    endproperty
    a_decay_pass: assert property (p_decay_pass)
        else $error("stepping decay code not passed through");

    c_motor_load:  cover property (@(posedge clk) disable iff (!reset_n)
                                   loadEdge && standbyAtLoad);
    c_init_load:   cover property (@(posedge clk) disable iff (!reset_n)
                                   loadEdge && !standbyAtLoad && !dataAtLoad);
    c_ext_load:    cover property (@(posedge clk) disable iff (!reset_n)
                                   loadEdge && !standbyAtLoad && dataAtLoad);
    c_blank:       cover property (@(posedge clk) disable iff (!reset_n)
                                   polarityToggle && next_dcMode);
    c_blank_end:   cover property (@(posedge clk) disable iff (!reset_n)
                                   noise_blank_interval && chopOscTick && blankCount == 3'h1);

endmodule : stepper_drive_word_latch

// *** tb/host_model.sv ***
// Host side model driving the pair one serial link
module host_model (
    // Serial link to the device
    output logic shiftClk,
    output logic serialData,
    output logic loadPulse
);
    timeunit 1ns;
    timeprecision 100ps;

    // Half period of the 125 ns link clock
    localparam realtime HALF = 62.5;

    // Idle link: clock still, strobe low
    initial begin
        shiftClk = 1'b0;
        serialData = 1'b0;
        loadPulse = 1'b0;
    end

    ////////////////////////////////////////////////////////////
    // Shift one word MSB first; clock runs only within the frame
    task automatic shift_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            serialData = w[i];
            #HALF shiftClk = 1'b1;
            #HALF shiftClk = 1'b0;
        end
    endtask : shift_word

    // Strobe with the latch select level held well around the rise
    task automatic load(input logic sel);
        serialData = sel;
        #400 loadPulse = 1'b1;
        #400 loadPulse = 1'b0;
        serialData = ~sel;
        #400;
    endtask : load
endmodule : host_model

// *** tb/stepper_drive_word_latch_tb.sv ***
// Self-checking bench for the serial drive word latch
module stepper_drive_word_latch_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic                           clk = 1'b0;
    logic                           reset_n = 1'b0;
    logic                           standbySelect = 1'b0;
    logic                           bridgePolarity = 1'b0;
    logic                           chargeStart = 1'b0;
    logic                           chopOscTick = 1'b0;
    logic                           sck;
    logic                           sdi;
    logic                           stb;
    logic [15:0]                    motorWord;
    logic [15:0]                    initWord;
    logic [15:0]                    extWord;
    logic [6:0]                     peakPct;
    drive_word_pkg::winding_drive_t wA;
    drive_word_pkg::winding_drive_t wB;
    logic                           motorOp;
    logic                           dcMode;
    logic                           blank;
    int                             num_errors = 0;
    int                             checks = 0;
    int                             seed = 46;
    logic [15:0]                    expMotor = 16'h0000;
    logic [15:0]                    expInit = 16'h0000;
    logic [15:0]                    expExt = 16'h0000;
    logic                           bitQ [$];
    int peakTab [4] = '{50, 70, 85, 100};
    int stepTab [16] = '{0, 10, 20, 29, 38, 47, 56, 63, 71, 77, 83, 88, 92, 96, 98, 100};
    int blankTab [4] = '{5, 2, 3, 4};

    // 25 MHz system clock
    always #20 clk = ~clk;

    // Host on the link, device under test
    host_model u_host (.shiftClk(sck), .serialData(sdi), .loadPulse(stb));
    stepper_drive_word_latch u_dut (
        .clk(clk), .reset_n(reset_n), .shift_clock_pair_one(sck),
        .serial_in_pair_one(sdi), .load_pulse_pair_one(stb),
        .standbySelect(standbySelect), .bridgePolarity(bridgePolarity),
        .chargeStart(chargeStart), .chopOscTick(chopOscTick),
        .motor_drive_word(motorWord), .initialSetupWord(initWord),
        .extendedSetupWord(extWord), .peakScalePct(peakPct), .windingA(wA),
        .windingB(wB), .motorOperation(motorOp), .dcMode(dcMode),
        .noise_blank_interval(blank));

    ////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    // Wait cycles, then let that edge settle
    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cycles

    // Change standby; a real change clears the motor latch
    task automatic set_standby(input logic v);
        if (v != standbySelect) expMotor = 16'h0000;
        @(posedge clk) standbySelect <= v;
        cycles(8);
    endtask : set_standby

    // Shift a word and keep the last 16 bits in the model queue
    task automatic shift(input logic [15:0] w);
        u_host.shift_word(w);
        for (int i = 15; i >= 0; i--) begin
            bitQ.push_back(w[i]);
            if (bitQ.size() > 16) begin
                void'(bitQ.pop_front());
            end
        end
    endtask : shift

    // Model shift register contents, oldest bit at the top
    function automatic logic [15:0] model_word();
        logic [15:0] m;
        m = 16'h0000;
        for (int i = 0; i < bitQ.size(); i++) begin
            m[15 - i] = bitQ[i];
        end
        return m;
    endfunction : model_word

    // Shift and load one word, updating the model latches
    task automatic write_word(input logic [15:0] w, input logic sel);
        shift(w);
        u_host.load(sel);
        if (standbySelect) expMotor = model_word();
        else if (sel) expExt = model_word();
        else expInit = model_word();
        cycles(2);
    endtask : write_word

    // One winding: f holds polarity, step and decay fields
    task automatic chk_wind(input string n, input drive_word_pkg::winding_drive_t s,
                            input logic [6:0] f, input logic dc);
        logic off;
        off = (f[5:2] == 4'h0);
        check({n, " decay"}, s.decay, dc ? 2'h3 : f[1:0]);
        check({n, " step"}, s.stepPct, stepTab[f[5:2]]);
        check({n, " off"}, s.off, off);
        check({n, " pos"}, s.posHigh, f[6] & !off);
        check({n, " neg"}, s.negHigh, !f[6] & !off);
    endtask : chk_wind

    // Latches and decoded outputs against the model
    task automatic check_all();
        logic dc;
        dc = !(expInit[2:0] inside {3'h0, 3'h1, 3'h2});
        check("motor", motorWord, expMotor);
        check("init", initWord, expInit);
        check("ext", extWord, expExt);
        check("dcMode", dcMode, dc);
        check("motorOp", motorOp, standbySelect);
        check("peak", peakPct, peakTab[expMotor[1:0]]);
        chk_wind("B", wB, expMotor[8:2], dc);
        chk_wind("A", wA, expMotor[15:9], dc);
    endtask : check_all

    // One oscillator tick
    task automatic tick();
        @(posedge clk) chopOscTick <= 1'b1;
        @(posedge clk) chopOscTick <= 1'b0;
        cycles(2);
    endtask : tick

    // Start blanking by charge start or polarity toggle
    task automatic kick(input bit viaPol);
        if (viaPol) begin
            @(posedge clk) bridgePolarity <= ~bridgePolarity;
            cycles(6);
        end else begin
            @(posedge clk) chargeStart <= 1'b1;
            @(posedge clk) chargeStart <= 1'b0;
            cycles(1);
        end
    endtask : kick

    // Blanking length in DC mode
    task automatic blank_test(input logic [1:0] sel, input bit viaPol);
        kick(viaPol);
        check("blank on", blank, 1'b1);
        repeat (blankTab[sel] - 1) tick();
        check("blank held", blank, 1'b1);
        tick();
        cycles(2);
        check("blank off", blank, 1'b0);
    endtask : blank_test

    // Verdict and end of run
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        #1000000;
        num_errors++;
        print_verdict();
    end

    // Main sequence
    initial begin
        logic [15:0] w;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        cycles(8);
        check_all();
        $display("test reset done");
        set_standby(1'b1);
        for (int i = 0; i < 12; i++) begin
            w = 16'($random(seed));
            w[1:0] = i[1:0];
            w[3:2] = i[1:0];
            w[10:9] = ~i[1:0];
            if (i == 4) w = (w & 16'h870F) | 16'hC000;
            if (i[0]) shift(16'($random(seed)));
            write_word(w, i[1]);
            check_all();
        end
        $display("test motor words done");
        w = 16'($random(seed));
        w[3:2] = 2'h1;
        shift(w);
        set_standby(1'b0);
        set_standby(1'b1);
        u_host.load(1'b0);
        expMotor = model_word();
        cycles(2);
        check_all();
        $display("test standby while shifting done");
        set_standby(1'b0);
        check_all();
        write_word(16'($random(seed)), 1'b1);
        write_word(16'h0019, 1'b0);
        check_all();
        kick(1'b0);
        kick(1'b1);
        check("blank stepper", blank, 1'b0);
        $display("test setup latches done");
        for (int k = 0; k < 4; k++) begin
            set_standby(1'b0);
            write_word({11'h000, 2'(k), 3'(k + 3)}, 1'b0);
            set_standby(1'b1);
            write_word(16'($random(seed)), 1'b0);
            check_all();
            blank_test(2'(k), k[0]);
        end
        $display("test dc mode done");
        @(posedge clk) reset_n <= 1'b0;
        cycles(4);
        @(posedge clk) reset_n <= 1'b1;
        cycles(8);
        expMotor = 16'h0000;
        expInit = 16'h0000;
        expExt = 16'h0000;
        check_all();
        $display("test second reset done");
        print_verdict();
    end
endmodule : stepper_drive_word_latch_tb
